// ---- core/hpcb_bank.v ----
// Purpose: Hub port configuration register slice and port numbering
// Assumes: Configuring agent writes before host enumeration
// Notes:   Remap registers are taken as two 4-bit-per-port fields
`timescale 1ns/100ps
`include "hpcb_regs.vh"

// What this block does
// - Power bit 0 picks ganged (0) or individual (1) port switching.
// - Second config byte bit 3 flags hub as part of composite device.
// - Third config byte bit 3 selects port numbering and disable method.
// - Numbering select 0 uses disable registers 0A and 0B for port enables.
// - Standard mode reports ports contiguously, shifting higher ports down.
// - Numbering select 1 takes mapping and disabling from FB and FC.
// - String descriptors answered only when third byte bit 0 is set.
// - Standard mode disables masked ports in any order; counts enabled.
// - Fixed-attachment mask bits 1 to 3 mark ports 1 to 3; rest reserved.
module hpcb_bank (
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr_stb,
	input  wire       rd_stb,
	input  wire       self_powered,
	output reg  [7:0] rdata,
	output reg        power_individual,
	output reg        composite_device,
	output reg        string_enable,
	output reg  [3:0] port_enable,
	output reg  [1:0] enabled_count,
	output reg  [1:0] host_num_p1,
	output reg  [1:0] host_num_p2,
	output reg  [1:0] host_num_p3,
	output reg  [3:0] fixed_ports
);

	reg  [7:0] hub_config_byte_one;
	reg  [7:0] hub_config_byte_two;
	reg  [7:0] hub_config_byte_three;
	reg  [7:0] fixed_attachment_mask;
	reg  [7:0] self_powered_disable_mask;
	reg  [7:0] bus_powered_disable_mask;
	reg  [7:0] remap_lo;
	reg  [7:0] remap_hi;
	reg        sp_meta;
	reg        sp_sync;
	reg  [7:0] next_rdata;
	reg  [3:0] next_enable;
	reg  [1:0] next_n1;
	reg  [1:0] next_n2;
	reg  [1:0] next_n3;
	wire [7:0] dis_mask;
	wire       numsel;
	wire       wr_byte_one;
	wire       wr_byte_two;
	wire       wr_byte_three;
	wire       wr_fixed;
	wire       wr_dis_sp;
	wire       wr_dis_bp;
	wire       wr_remap_a;
	wire       wr_remap_b;
	wire [3:0] std_enable;
	wire [1:0] std_n1;
	wire [1:0] std_n2;
	wire [1:0] std_n3;
	wire [3:0] map_enable;
	wire [1:0] map_n1;
	wire [1:0] map_n2;
	wire [1:0] map_n3;
	wire [1:0] next_count;

	// One decode per register; unmapped offsets match none
	assign wr_byte_one   = wr_stb && (addr == `HPCB_OFF_BYTE_ONE);
	assign wr_byte_two   = wr_stb && (addr == `HPCB_OFF_BYTE_TWO);
	assign wr_byte_three = wr_stb && (addr == `HPCB_OFF_BYTE_THREE);
	assign wr_fixed      = wr_stb && (addr == `HPCB_OFF_FIXED);
	assign wr_dis_sp     = wr_stb && (addr == `HPCB_OFF_DIS_SP);
	assign wr_dis_bp     = wr_stb && (addr == `HPCB_OFF_DIS_BP);
	assign wr_remap_a    = wr_stb && (addr == `HPCB_OFF_REMAP_A);
	assign wr_remap_b    = wr_stb && (addr == `HPCB_OFF_REMAP_B);

	// Standard numbering: each enabled port takes the next free number
	assign std_enable = {~dis_mask[3:1], 1'b0};
	assign std_n1     = std_enable[1] ? 2'h1 : 2'h0;
	assign std_n2     = std_enable[2] ?
		(2'h1 + {1'b0, std_enable[1]}) : 2'h0;
	assign std_n3     = std_enable[3] ? (2'h1 + {1'b0, std_enable[1]}
		+ {1'b0, std_enable[2]}) : 2'h0;

	// Remap: a zero field disables that port, so the count stays honest
	assign map_n1     = remap_lo[1:0];
	assign map_n2     = remap_lo[5:4];
	assign map_n3     = remap_hi[1:0];
	assign map_enable = {|map_n3, |map_n2, |map_n1, 1'b0};

	// Two bits suffice: at most three ports
	assign next_count = {1'b0, next_enable[1]} + {1'b0, next_enable[2]}
		+ {1'b0, next_enable[3]};

	assign numsel   = hub_config_byte_three[`HPCB_BIT_NUMSEL];
	// Power source strap is a pin, so it is synchronised first
	assign dis_mask = sp_sync ? self_powered_disable_mask
	                          : bus_powered_disable_mask;

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_meta <= 1'b0;
			sp_sync <= 1'b0;
		end else begin
			sp_meta <= self_powered;
			sp_sync <= sp_meta;
		end
	end

	// Register writes; reserved bits of config and mask registers never stored
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hub_config_byte_one       <= `HPCB_RST_BYTE_ONE;
			hub_config_byte_two       <= `HPCB_RST_BYTE_TWO;
			hub_config_byte_three     <= `HPCB_RST_BYTE_THREE;
			fixed_attachment_mask     <= `HPCB_RST_MASK;
			self_powered_disable_mask <= `HPCB_RST_MASK;
			bus_powered_disable_mask  <= `HPCB_RST_MASK;
			remap_lo                  <= `HPCB_RST_MASK;
			remap_hi                  <= `HPCB_RST_MASK;
		end else begin
			// Reserved bits masked on the way in, so reads need no mask
			if (wr_byte_one) begin
				hub_config_byte_one <= wdata & `HPCB_MASK_BYTE_ONE;
			end
			if (wr_byte_two) begin
				hub_config_byte_two <=
					wdata & `HPCB_MASK_BYTE_TWO;
			end
			if (wr_byte_three) begin
				hub_config_byte_three <=
					wdata & `HPCB_MASK_BYTE_THREE;
			end
			if (wr_fixed) begin
				fixed_attachment_mask <= wdata & `HPCB_MASK_PORTS;
			end
			if (wr_dis_sp) begin
				self_powered_disable_mask <= wdata & `HPCB_MASK_PORTS;
			end
			if (wr_dis_bp) begin
				bus_powered_disable_mask <= wdata & `HPCB_MASK_PORTS;
			end
			// Remap fields sit at four-bit spacing; spare bits kept
			if (wr_remap_a) begin
				remap_lo <= wdata;
			end
			if (wr_remap_b) begin
				remap_hi <= wdata;
			end
		end
	end

	// Read mux; unmapped offsets read zero
	always @* begin
		case (addr)
		`HPCB_OFF_BYTE_ONE:   next_rdata = hub_config_byte_one;
		`HPCB_OFF_BYTE_TWO:   next_rdata = hub_config_byte_two;
		`HPCB_OFF_BYTE_THREE: next_rdata = hub_config_byte_three;
		`HPCB_OFF_FIXED:   next_rdata = fixed_attachment_mask;
		`HPCB_OFF_DIS_SP:  next_rdata = self_powered_disable_mask;
		`HPCB_OFF_DIS_BP:  next_rdata = bus_powered_disable_mask;
		`HPCB_OFF_REMAP_A: next_rdata = remap_lo;
		`HPCB_OFF_REMAP_B: next_rdata = remap_hi;
		`HPCB_OFF_STATUS:
			next_rdata = {2'b00, enabled_count, port_enable[3:1], 1'b0};
		default:           next_rdata = 8'h00;
		endcase
	end

	// Port numbering: standard packs enabled ports, remap takes fields
	always @* begin
		next_enable = 4'h0;
		next_n1     = 2'h0;
		next_n2     = 2'h0;
		next_n3     = 2'h0;
		if (!numsel) begin
			next_enable = std_enable;
			next_n1     = std_n1;
			next_n2     = std_n2;
			next_n3     = std_n3;
		end else begin
			next_enable = map_enable;
			next_n1     = map_n1;
			next_n2     = map_n2;
			next_n3     = map_n3;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata            <= 8'h00;
			power_individual <= 1'b0;
			composite_device <= 1'b0;
			string_enable    <= 1'b0;
			port_enable      <= 4'h0;
			enabled_count    <= 2'h0;
			host_num_p1      <= 2'h0;
			host_num_p2      <= 2'h0;
			host_num_p3      <= 2'h0;
			fixed_ports      <= 4'h0;
		end else begin
			rdata            <= rd_stb ? next_rdata : 8'h00;
			power_individual <= hub_config_byte_one[`HPCB_BIT_PWR];
			composite_device <=
				hub_config_byte_two[`HPCB_BIT_COMPOSITE];
			string_enable <= hub_config_byte_three[`HPCB_BIT_STRING];
			port_enable   <= next_enable;
			enabled_count <= next_count;
			host_num_p1   <= next_n1;
			host_num_p2   <= next_n2;
			host_num_p3   <= next_n3;
			// Composite flag relies on agent marking ports here
			fixed_ports   <= fixed_attachment_mask[3:0];
		end
	end

endmodule // hpcb_bank

// ---- core/hpcb_regs.vh ----
// Purpose: Offsets, fields and reset values of the hub port config bank
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Reset values are plain defaults
`ifndef HPCB_REGS_VH
`define HPCB_REGS_VH

`define HPCB_OFF_BYTE_ONE   8'h06
`define HPCB_OFF_BYTE_TWO   8'h07
`define HPCB_OFF_BYTE_THREE 8'h08
`define HPCB_OFF_FIXED      8'h09
`define HPCB_OFF_DIS_SP     8'h0a
`define HPCB_OFF_DIS_BP     8'h0b
`define HPCB_OFF_REMAP_A    8'hfb
`define HPCB_OFF_REMAP_B    8'hfc
`define HPCB_OFF_STATUS     8'h80

`define HPCB_BIT_PWR        0
`define HPCB_BIT_COMPOSITE  3
`define HPCB_BIT_NUMSEL     3
`define HPCB_BIT_STRING     0

`define HPCB_MASK_BYTE_ONE  8'h01
`define HPCB_MASK_BYTE_TWO  8'h08
`define HPCB_MASK_BYTE_THREE 8'h09
`define HPCB_MASK_PORTS     8'h0e

`define HPCB_RST_BYTE_ONE   8'h00
`define HPCB_RST_BYTE_TWO   8'h00
`define HPCB_RST_BYTE_THREE 8'h00
`define HPCB_RST_MASK       8'h00

`endif

// ---- bench/hpcb_agent.sv ----
// Purpose: Agent side, drives the supply-sense pin
// Assumes: Bench picks the level per test
// Notes:   Moves only after an edge, like a strap
`timescale 1ns/100ps
module hpcb_agent (
	input  logic ref_clk,
	input  logic want_sp,
	output logic self_powered
);
	always @(posedge ref_clk) self_powered <= want_sp;
endmodule // hpcb_agent

// ---- bench/hpcb_chk_assertions.sv ----
// Purpose: Port checks of the config bank
// Assumes: Bound to hpcb_bank
// Notes:   Write effects land two edges on
`timescale 1ns/100ps
module hpcb_chk (
	input logic       ref_clk,
	input logic       rst_n,
	input logic [7:0] addr,
	input logic [7:0] wdata,
	input logic       wr_stb,
	input logic       rd_stb,
	input logic [7:0] rdata,
	input logic       power_individual,
	input logic       composite_device,
	input logic       string_enable,
	input logic [3:0] port_enable,
	input logic [1:0] enabled_count,
	input logic [3:0] fixed_ports
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_rdata_idle: assert property (
		!$past(rd_stb) |-> rdata == 8'h00)
		else $error("read data not idle");
	a_power_write: assert property (
		wr_stb && addr == 8'h06
		|-> ##2 power_individual == $past(wdata[0], 2))
		else $error("power mode");
	a_compound_write: assert property (
		wr_stb && addr == 8'h07
		|-> ##2 composite_device == $past(wdata[3], 2))
		else $error("composite flag");
	a_string_write: assert property (
		wr_stb && addr == 8'h08
		|-> ##2 string_enable == $past(wdata[0], 2))
		else $error("string enable");
	a_byte_two_rsvd: assert property (
		rd_stb && addr == 8'h07 |=> (rdata & 8'hf7) == 8'h00)
		else $error("byte two reserved bits");
	a_byte_three_rsvd: assert property (
		rd_stb && addr == 8'h08 |=> (rdata & 8'hf6) == 8'h00)
		else $error("byte three reserved bits");
	a_count_match: assert property (
		enabled_count == $countones(port_enable) && !port_enable[0])
		else $error("port count");
	a_fixed_write: assert property (
		wr_stb && addr == 8'h09
		|-> ##2 fixed_ports == ($past(wdata, 2) & 8'h0e))
		else $error("fixed mask");
	a_status_read: assert property (
		rd_stb && addr == 8'h80 |=> rdata == {2'b00, $past(enabled_count),
		$past(port_enable[3:1]), 1'b0})
		else $error("status read");
endmodule // hpcb_chk

// ---- bench/tb_top.sv ----
// Purpose: Directed register tests of the config bank
// Assumes: Outputs settle within six edges
// Notes:   Pin sync is slow, so checks wait six
`timescale 1ns/100ps
module tb_top;
	logic       ref_clk = 1'b0, rst_n = 1'b0, want_sp = 1'b1;
	logic       wr_stb = 1'b0, rd_stb = 1'b0, self_powered;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic       power_individual, composite_device, string_enable;
	logic [3:0] port_enable, fixed_ports;
	logic [1:0] enabled_count, host_num_p1, host_num_p2, host_num_p3;
	int         mismatches = 0, n_compared = 0;
	always #5 ref_clk = ~ref_clk;
	hpcb_agent hpcb_agent_inst (
		.ref_clk      (ref_clk),
		.want_sp      (want_sp),
		.self_powered (self_powered)
	);
	hpcb_bank hpcb_bank_inst (
		.ref_clk          (ref_clk),
		.rst_n            (rst_n),
		.addr             (addr),
		.wdata            (wdata),
		.wr_stb           (wr_stb),
		.rd_stb           (rd_stb),
		.self_powered     (self_powered),
		.rdata            (rdata),
		.power_individual (power_individual),
		.composite_device (composite_device),
		.string_enable    (string_enable),
		.port_enable      (port_enable),
		.enabled_count    (enabled_count),
		.host_num_p1      (host_num_p1),
		.host_num_p2      (host_num_p2),
		.host_num_p3      (host_num_p3),
		.fixed_ports      (fixed_ports)
	);
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t read %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [18:0] got, input logic [18:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t outputs %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1 chk_reg(rdata, exp);
	endtask
	task automatic see(input logic [18:0] exp);
		repeat (6) @(posedge ref_clk);
		#1 chk_out({power_individual, composite_device, string_enable,
			port_enable, enabled_count, host_num_p1, host_num_p2,
			host_num_p3, fixed_ports}, exp);
	endtask
	task automatic test_done;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		see({3'b000, 4'he, 2'd3, 2'd1, 2'd2, 2'd3, 4'h0});
		rd(8'h07, 8'h00);
		wr(8'h06, 8'hff);
		wr(8'h07, 8'hff);
		wr(8'h09, 8'hff);
		rd(8'h06, 8'h01);
		rd(8'h07, 8'h08);
		rd(8'h09, 8'h0e);
		see({3'b110, 4'he, 2'd3, 2'd1, 2'd2, 2'd3, 4'he});
		$display("flags test done");
		wr(8'h0a, 8'h04);
		wr(8'h0b, 8'h0a);
		see({3'b110, 4'ha, 2'd2, 2'd1, 2'd0, 2'd2, 4'he});
		@(posedge ref_clk);
		want_sp <= 1'b0;
		see({3'b110, 4'h4, 2'd1, 2'd0, 2'd1, 2'd0, 4'he});
		$display("standard test done");
		wr(8'hfb, 8'h13);
		wr(8'hfc, 8'h02);
		wr(8'h06, 8'h00);
		wr(8'h08, 8'hff);
		rd(8'h08, 8'h09);
		see({3'b011, 4'he, 2'd3, 2'd3, 2'd1, 2'd2, 4'he});
		rd(8'h80, 8'h3e);
		wr(8'h40, 8'hff);
		rd(8'h40, 8'h00);
		$display("remap test done");
		test_done;
	end
endmodule // tb_top
bind hpcb_bank hpcb_chk hpcb_chk_inst (
	.ref_clk          (ref_clk),
	.rst_n            (rst_n),
	.addr             (addr),
	.wdata            (wdata),
	.wr_stb           (wr_stb),
	.rd_stb           (rd_stb),
	.rdata            (rdata),
	.power_individual (power_individual),
	.composite_device (composite_device),
	.string_enable    (string_enable),
	.port_enable      (port_enable),
	.enabled_count    (enabled_count),
	.fixed_ports      (fixed_ports)
);
